/* File: core/lcd_bias_pkg.sv */
// package: register map, field positions, reset values and timing constants for the lcd clock and bias block
package lcd_bias_pkg;
  localparam logic [11:0] OFS_CONTROL   = 12'h000;
  localparam logic [11:0] OFS_PHASE     = 12'h004;
  localparam logic [11:0] OFS_LADDER    = 12'h008;
  localparam logic [11:0] OFS_CONTRAST  = 12'h00c;
  localparam logic [11:0] OFS_REFERENCE = 12'h010;
  localparam logic [7:0]  RST_CONTROL   = 8'h03;
  localparam logic [7:0]  RST_PHASE     = 8'h00;
  localparam logic [7:0]  RST_LADDER    = 8'h00;
  localparam logic [7:0]  RST_CONTRAST  = 8'h00;
  localparam logic [7:0]  RST_REFERENCE = 8'h00;
  // control: bit7 enable, bit6 sleep disable, bits3-2 clock select
  localparam int CTL_EN = 7;
  localparam int CTL_SLP = 6;
  localparam int CTL_CS_LO = 2;
  // phase: bit7 waveform type, bit6 half bias, bit5 active (read only), bits3-0 prescale
  localparam int PH_WFT = 7;
  localparam int PH_BIAS = 6;
  localparam int PH_ACT = 5;
  localparam int LAD_AP_LO = 6;
  localparam int LAD_BP_LO = 4;
  localparam int REF_EN = 7;
  localparam int REF_SRC = 6;
  localparam int REF_IDLE = 5;
  localparam logic [7:0] MASK_CONTROL   = 8'hcf;
  localparam logic [7:0] MASK_PHASE     = 8'hcf;
  localparam logic [7:0] MASK_LADDER    = 8'hf7;
  localparam logic [7:0] MASK_CONTRAST  = 8'h07;
  localparam logic [7:0] MASK_REFERENCE = 8'hee;
  localparam logic [1:0] CS_SYSDIV = 2'h0;
  localparam logic [1:0] CS_TIMER1 = 2'h1;
  localparam logic [7:0] SYSDIV_LAST = 8'hff;
  localparam logic [4:0] TYPEA_LAST = 5'h0f;
  localparam logic [4:0] TYPEB_LAST = 5'h1f;
  localparam logic [1:0] PWR_OFF = 2'h0;
  typedef enum logic [1:0] {PWR_OFF_E, PWR_LOW, PWR_MED, PWR_HIGH} ladder_power_t;
endpackage

/* File: core/lcd_clock_and_bias_ladder_control.sv */
// lcd clock source selection, frame prescaler and reference ladder power sequencing
// Notes on behaviour
// - three clock sources chosen by a two-bit clock select field
// - system clock path divides by fixed 256, not programmable
// - timer1 and internal oscillator sources keep running during sleep
// - hidden four-bit counter prescales selected clock, 1:1 to 1:16
// - half and third bias with three and four levels
// - half bias shorts the middle of three ladder resistors
// - ladder has low, medium, high power and off, off disconnects all
// - inactive display forces the reference ladder off
// - mode A after each transition for programmed time, then mode B
// - A/B timing taken from five-bit prescaler of the 32 kHz clock
// - power fields encode off, low, medium, high
// - type A: n clocks in A, 16-n in B; zero means always B
// - type B: n clocks in A, 32-n in B; zero means always B
// - three-bit contrast field sets eight-tap contrast ladder
// - inactive display opens the contrast ladder
// - reference from io supply or 3x fixed reference; none disables contrast
// - inactive display turns the internal reference off
// - idle bit with fixed reference disables its buffer during mode B
// - fixed reference enabled automatically when the lcd reference needs it
// - each external bias pin has its own connect control
`timescale 1ns/10ps
module lcd_clock_and_bias_ladder_control
  import lcd_bias_pkg::*;
(
  input  wire logic        sys_clk_i,        // system clock, 125 MHz
  input  wire logic        srst_i,           // synchronous reset, active high
  input  wire logic        psel_i,           // apb select
  input  wire logic        penable_i,        // apb enable
  input  wire logic        pwrite_i,         // apb direction
  input  wire logic [11:0] paddr_i,          // apb byte address
  input  wire logic [31:0] pwdata_i,         // apb write data
  output logic      [31:0] prdata_o,         // apb read data
  output logic             pready_o,         // apb ready
  output logic             pslverr_o,        // apb error on unmapped address
  input  wire logic        timer1_osc_i,     // timer1 crystal oscillator pin
  input  wire logic        lfosc_i,          // low-frequency internal oscillator
  input  wire logic        ref32k_i,         // 32 kHz ladder timing clock
  input  wire logic        sleep_i,          // processor in sleep (async)
  output logic             lcd_clk_en_o,     // prescaled lcd clock pulse
  output logic             display_active_o, // display active flag
  output logic [1:0]       ladder_power_o,   // ladder power: off/low/med/high
  output logic             ladder_mode_a_o,  // ladder in power mode A
  output logic             ladder_short_mid_o, // short middle ladder resistor
  output logic [2:0]       contrast_tap_o,   // contrast ladder tap
  output logic             contrast_open_o,  // contrast ladder opened
  output logic             ref_enable_o,     // internal bias reference on
  output logic             ref_from_fvr_o,   // reference is 3x fixed reference
  output logic             fvr_request_o,    // fixed reference enable request
  output logic             fvr_buffer_en_o,  // fixed reference buffer enable
  output logic [2:0]       ext_pin_connect_o // bias pin connects, bit0 = pin1
);

  logic [7:0] control, phase, ladder, contrast, reference;
  logic [2:0] t1_sync, lf_sync, r32_sync;
  logic [1:0] slp_sync;
  logic       t1_tick, lf_tick, r32_tick;
  logic [7:0] sysdiv;
  logic       sys_tick, src_tick;
  logic [3:0] pre_cnt;
  logic [4:0] phase_cnt;
  logic       active;
  logic       in_a, next_in_a;
  logic       wr_en, rd_en;
  logic       sel_control, sel_phase, sel_ladder, sel_contrast, sel_reference;
  logic       mapped;

  // stage 1 only feeds stage 2; edge detect uses stages 2 and 3
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      t1_sync  <= 3'h0;
      lf_sync  <= 3'h0;
      r32_sync <= 3'h0;
      slp_sync <= 2'h0;
    end else begin
      t1_sync  <= {t1_sync[1:0], timer1_osc_i};
      lf_sync  <= {lf_sync[1:0], lfosc_i};
      r32_sync <= {r32_sync[1:0], ref32k_i};
      slp_sync <= {slp_sync[0], sleep_i};
    end
  end
  assign t1_tick  = t1_sync[1] & ~t1_sync[2];
  assign lf_tick  = lf_sync[1] & ~lf_sync[2];
  assign r32_tick = r32_sync[1] & ~r32_sync[2];

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      sysdiv <= 8'h00;
    end else begin
      sysdiv <= sysdiv + 8'h01;
    end
  end
  assign sys_tick = (sysdiv == SYSDIV_LAST);

  // sleep stops the system path only; oscillator sources run on
  always_comb begin
    if (control[CTL_CS_LO+1]) begin
      src_tick = lf_tick;
    end else if (control[CTL_CS_LO +: 2] == CS_TIMER1) begin
      src_tick = t1_tick;
    end else begin
      src_tick = sys_tick & ~slp_sync[1];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      pre_cnt      <= 4'h0;
      lcd_clk_en_o <= 1'b0;
    end else begin
      lcd_clk_en_o <= 1'b0;
      if (!active) begin
        pre_cnt <= 4'h0;
      end else if (src_tick) begin
        if (pre_cnt >= phase[3:0]) begin
          pre_cnt      <= 4'h0;
          lcd_clk_en_o <= 1'b1;
        end else begin
          pre_cnt <= pre_cnt + 4'h1;
        end
      end
    end
  end

  // active follows enable; sleep with the sleep-disable bit set shuts down
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      active <= 1'b0;
    end else begin
      active <= control[CTL_EN] & ~(control[CTL_SLP] & slp_sync[1]);
    end
  end

  // five-bit 32 kHz phase counter; wraps at 16 for type A, 32 for type B
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      phase_cnt <= 5'h00;
    end else if (!active) begin
      phase_cnt <= 5'h00;
    end else if (r32_tick) begin
      if (phase_cnt >= (phase[PH_WFT] ? TYPEB_LAST : TYPEA_LAST)) begin
        phase_cnt <= 5'h00;
      end else begin
        phase_cnt <= phase_cnt + 5'h01;
      end
    end
  end

  always_comb begin
    next_in_a = (phase_cnt < {2'h0, ladder[2:0]});
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      in_a <= 1'b0;
    end else begin
      in_a <= next_in_a & active;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      display_active_o <= 1'b0;
    end else begin
      display_active_o <= active;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      ladder_mode_a_o <= 1'b0;
    end else begin
      ladder_mode_a_o <= in_a;
    end
  end

  // an inactive display overrides both programmed power fields
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      ladder_power_o <= PWR_OFF;
    end else if (!active) begin
      ladder_power_o <= PWR_OFF;
    end else if (in_a) begin
      ladder_power_o <= ladder[LAD_AP_LO +: 2];
    end else begin
      ladder_power_o <= ladder[LAD_BP_LO +: 2];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      ladder_short_mid_o <= 1'b0;
    end else begin
      ladder_short_mid_o <= phase[PH_BIAS];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      contrast_tap_o <= 3'h0;
    end else begin
      contrast_tap_o <= contrast[2:0];
    end
  end

  // open after reset so the glass sees no contrast load before setup
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      contrast_open_o <= 1'b1;
    end else begin
      contrast_open_o <= ~active | ~reference[REF_EN];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      ref_enable_o <= 1'b0;
    end else begin
      ref_enable_o <= active & reference[REF_EN];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      ref_from_fvr_o <= 1'b0;
    end else begin
      ref_from_fvr_o <= reference[REF_SRC];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      fvr_request_o <= 1'b0;
    end else begin
      fvr_request_o <= active & reference[REF_EN] & reference[REF_SRC];
    end
  end

  // buffer follows the registered mode, so it drops together with the ladder power
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      fvr_buffer_en_o <= 1'b0;
    end else begin
      fvr_buffer_en_o <= active & reference[REF_EN] & reference[REF_SRC]
                         & ~(reference[REF_IDLE] & ~in_a);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      ext_pin_connect_o <= 3'h0;
    end else begin
      ext_pin_connect_o <= reference[3:1];
    end
  end

  assign wr_en = psel_i & penable_i & pwrite_i;
  assign rd_en = psel_i & ~penable_i & ~pwrite_i;

  // one decode shared by the write, read and error paths
  always_comb begin
    sel_control   = 1'b0;
    sel_phase     = 1'b0;
    sel_ladder    = 1'b0;
    sel_contrast  = 1'b0;
    sel_reference = 1'b0;
    if (paddr_i == OFS_CONTROL) begin
      sel_control = 1'b1;
    end else if (paddr_i == OFS_PHASE) begin
      sel_phase = 1'b1;
    end else if (paddr_i == OFS_LADDER) begin
      sel_ladder = 1'b1;
    end else if (paddr_i == OFS_CONTRAST) begin
      sel_contrast = 1'b1;
    end else if (paddr_i == OFS_REFERENCE) begin
      sel_reference = 1'b1;
    end
  end
  assign mapped = sel_control | sel_phase | sel_ladder | sel_contrast | sel_reference;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      control <= RST_CONTROL;
    end else if (wr_en && sel_control) begin
      control <= pwdata_i[7:0] & MASK_CONTROL;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      phase <= RST_PHASE;
    end else if (wr_en && sel_phase) begin
      phase <= pwdata_i[7:0] & MASK_PHASE;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      ladder <= RST_LADDER;
    end else if (wr_en && sel_ladder) begin
      ladder <= pwdata_i[7:0] & MASK_LADDER;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      contrast <= RST_CONTRAST;
    end else if (wr_en && sel_contrast) begin
      contrast <= pwdata_i[7:0] & MASK_CONTRAST;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      reference <= RST_REFERENCE;
    end else if (wr_en && sel_reference) begin
      reference <= pwdata_i[7:0] & MASK_REFERENCE;
    end
  end

  // zero wait states: ready rises in the access cycle after every setup
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      pready_o <= 1'b0;
    end else begin
      pready_o <= psel_i & ~penable_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      pslverr_o <= 1'b0;
    end else begin
      pslverr_o <= psel_i & ~penable_i & ~mapped;
    end
  end

  // read data captured in setup and held until the next read setup
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (rd_en) begin
      if (sel_control) begin
        prdata_o <= {24'h00_0000, control};
      end else if (sel_phase) begin
        prdata_o <= {24'h00_0000, phase[7:6], active, phase[4:0]};
      end else if (sel_ladder) begin
        prdata_o <= {24'h00_0000, ladder};
      end else if (sel_contrast) begin
        prdata_o <= {24'h00_0000, contrast};
      end else if (sel_reference) begin
        prdata_o <= {24'h00_0000, reference};
      end else begin
        prdata_o <= 32'h0000_0000;
      end
    end
  end

endmodule

/* File: tb/lcd_bias_props.sv */
// port-level assertions for the lcd clock and bias block
`timescale 1ns/10ps
module lcd_bias_props (
  input wire logic       sys_clk_i,        // clock
  input wire logic       srst_i,           // reset
  input wire logic       psel_i,           // apb select
  input wire logic       penable_i,        // apb enable
  input wire logic       pready_o,         // apb ready
  input wire logic       pslverr_o,        // apb error
  input wire logic       lcd_clk_en_o,     // lcd clock pulse
  input wire logic       display_active_o, // active flag
  input wire logic [1:0] ladder_power_o,   // ladder power
  input wire logic       contrast_open_o,  // contrast open
  input wire logic       ref_enable_o,     // reference on
  input wire logic       ref_from_fvr_o,   // fixed ref source
  input wire logic       fvr_request_o,    // fixed ref request
  input wire logic       fvr_buffer_en_o   // fixed ref buffer
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  a_ready_after_setup: assert property (psel_i && !penable_i |=> pready_o)
    else $error("no ready in access cycle");
  a_error_with_ready: assert property (pslverr_o |-> pready_o && psel_i && penable_i)
    else $error("error outside access");
  a_idle_no_clock: assert property (!display_active_o [*3] |-> !lcd_clk_en_o)
    else $error("lcd clock while inactive");
  a_idle_ladder_off: assert property (!display_active_o [*3] |-> ladder_power_o == 2'h0 && !ref_enable_o)
    else $error("ladder or reference on while inactive");
  a_contrast_tracks_ref: assert property (contrast_open_o != ref_enable_o)
    else $error("contrast ladder state wrong");
  a_fvr_need: assert property (fvr_request_o |-> ref_enable_o && ref_from_fvr_o)
    else $error("fixed ref requested without need");
  a_fvr_auto_on: assert property (ref_enable_o && ref_from_fvr_o |-> fvr_request_o)
    else $error("fixed ref not requested");
  a_buffer_needs_fvr: assert property (fvr_buffer_en_o |-> fvr_request_o)
    else $error("buffer on without fixed ref");
endmodule
bind lcd_clock_and_bias_ladder_control lcd_bias_props props (.sys_clk_i, .srst_i, .psel_i, .penable_i, .pready_o,
  .pslverr_o, .lcd_clk_en_o, .display_active_o, .ladder_power_o, .contrast_open_o, .ref_enable_o, .ref_from_fvr_o,
  .fvr_request_o, .fvr_buffer_en_o);

/* File: tb/lcd_clock_sources_model.sv */
// oscillator sources feeding the lcd block: timer1 crystal, internal slow osc, 32 kHz ladder clock
`timescale 1ns/10ps
module lcd_clock_sources_model (
  input  wire logic osc_enable_i, // timer1 oscillator enable
  output logic      timer1_osc_o, // crystal output
  output logic      lfosc_o,      // internal slow osc
  output logic      ref32k_o      // ladder timing clock
);
  logic t1_run;
  // periods scaled to 20, 24 and 16 system cycles; the block only counts edges
  initial begin
    t1_run = 1'b0;
    lfosc_o = 1'b0;
    ref32k_o = 1'b0;
    #3;
    fork
      forever #80 t1_run = ~t1_run;
      forever #96 lfosc_o = ~lfosc_o;
      forever #64 ref32k_o = ~ref32k_o;
    join
  end
  // the crystal stands still until software starts its oscillator
  assign timer1_osc_o = t1_run & osc_enable_i;
endmodule

/* File: tb/test_lcd_clock_and_bias_ladder_control.sv */
// self-checking bench: registers over apb, clock source periods, ladder power sequencing
`timescale 1ns/10ps
module test_lcd_clock_and_bias_ladder_control;
  import lcd_bias_pkg::*;
  logic        sys_clk_i = 1'b0, srst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, sleep_i = 1'b0;
  logic        osc_on = 1'b0, err, timer1_osc_i, lfosc_i, ref32k_i, pready_o, pslverr_o, lcd_clk_en_o;
  logic        display_active_o, ladder_mode_a_o, ladder_short_mid_o, contrast_open_o, ref_enable_o;
  logic        ref_from_fvr_o, fvr_request_o, fvr_buffer_en_o;
  logic [1:0]  ladder_power_o;
  logic [2:0]  contrast_tap_o, ext_pin_connect_o;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0000_0000, prdata_o, rd;
  int          num_errors = 0, samples_checked = 0, n;
  int          per[4] = '{256, 20, 24, 24}, cv[6] = '{0, 1, 2, 3, 1, 0}, pv[6] = '{2, 2, 2, 2, 15, 0};
  logic [11:0] ofs[5] = '{OFS_CONTROL, OFS_PHASE, OFS_LADDER, OFS_CONTRAST, OFS_REFERENCE};
  logic [7:0]  rst[5] = '{RST_CONTROL, RST_PHASE, RST_LADDER, RST_CONTRAST, RST_REFERENCE};
  logic [7:0]  rv[5] = '{8'h4f, MASK_PHASE, MASK_LADDER, MASK_CONTRAST, 8'hee};
  lcd_clock_and_bias_ladder_control dut (.sys_clk_i, .srst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .timer1_osc_i, .lfosc_i, .ref32k_i, .sleep_i, .lcd_clk_en_o, .display_active_o,
    .ladder_power_o, .ladder_mode_a_o, .ladder_short_mid_o, .contrast_tap_o, .contrast_open_o, .ref_enable_o,
    .ref_from_fvr_o, .fvr_request_o, .fvr_buffer_en_o, .ext_pin_connect_o);
  lcd_clock_sources_model far (.osc_enable_i(osc_on), .timer1_osc_o(timer1_osc_i), .lfosc_o(lfosc_i), .ref32k_o(ref32k_i));
  initial begin
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  task automatic tally_and_finish;
    if (num_errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    do @(posedge sys_clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk("prdata", e, rd);
    chk("pslverr", 32'h0000_0000, 32'(err));
  endtask
  function automatic logic sig(input int w);
    return w ? ladder_mode_a_o : lcd_clk_en_o;
  endfunction
  // skips the run in progress so that only whole runs are counted
  task automatic span(input int w, input logic v, output int c);
    c = 0;
    while (sig(w) === v) @(posedge sys_clk_i);
    while (sig(w) !== v) @(posedge sys_clk_i);
    while (sig(w) === v && c < 20000) begin
      @(posedge sys_clk_i);
      c++;
    end
  endtask
  initial begin
    #400000;
    num_errors++;
    tally_and_finish;
  end
  initial begin
    repeat (3) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    @(posedge sys_clk_i);
    chk("contrast_open", 1, contrast_open_o);
    for (int i = 0; i < 5; i++) rdc(ofs[i], rst[i]);
    apb(1'b0, 12'h014, 32'h0000_0000);
    chk("unmapped_err", 1, err);
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, ofs[i], (i == 0) ? 32'h0000_004f : 32'h0000_00ff);
      rdc(ofs[i], rv[i]);
    end
    chk("pins_mid_tap", 32'h0000_00fe, {ext_pin_connect_o, ladder_short_mid_o, contrast_tap_o, ref_enable_o});
    osc_on <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, OFS_PHASE, 32'(pv[i]));
      apb(1'b1, OFS_CONTROL, 32'(128 + 4 * cv[i]));
      span(0, 1'b0, n);
      span(0, 1'b0, n);
      chk("clk_period", per[cv[i]] * (pv[i] + 1), n + 1);
    end
    rdc(OFS_PHASE, 32'h0000_0020);
    apb(1'b1, OFS_CONTROL, 32'h0000_0084);
    sleep_i <= 1'b1;
    span(0, 1'b0, n);
    span(0, 1'b0, n);
    chk("sleep_period", 20, n + 1);
    apb(1'b1, OFS_CONTROL, 32'h0000_0080);
    n = 0;
    repeat (700) @(posedge sys_clk_i) n += (lcd_clk_en_o !== 1'b0);
    chk("sleep_sysdiv", 0, n);
    apb(1'b1, OFS_CONTROL, 32'h0000_00c4);
    repeat (8) @(posedge sys_clk_i);
    chk("sleep_off", 0, display_active_o);
    sleep_i <= 1'b0;
    apb(1'b1, OFS_CONTROL, 32'h0000_0084);
    apb(1'b1, OFS_REFERENCE, 32'h0000_00e0);
    apb(1'b1, OFS_LADDER, 32'h0000_00d3);
    for (int w = 0; w < 2; w++) begin
      apb(1'b1, OFS_PHASE, 32'(w * 128));
      span(1, 1'b1, n);
      chk("a_len", 48, n);
      repeat (2) @(posedge sys_clk_i);
      chk("b_power_buf", 32'h0000_0002, {ladder_power_o, fvr_buffer_en_o});
      span(1, 1'b0, n);
      chk("b_len", (13 + 16 * w) * 16, n);
      repeat (2) @(posedge sys_clk_i);
      chk("a_power_buf", 32'h0000_000f, {ladder_power_o, fvr_buffer_en_o, fvr_request_o});
    end
    apb(1'b1, OFS_LADDER, 32'h0000_00d0);
    repeat (2) @(posedge sys_clk_i);
    n = 0;
    repeat (700) @(posedge sys_clk_i) n += (ladder_mode_a_o !== 1'b0);
    chk("never_a", 0, n);
    apb(1'b1, OFS_REFERENCE, 32'h0000_0080);
    repeat (4) @(posedge sys_clk_i);
    chk("io_supply_ref", 32'h0000_0004, {ref_enable_o, ref_from_fvr_o, fvr_request_o});
    apb(1'b1, OFS_CONTROL, 32'h0000_0004);
    repeat (8) @(posedge sys_clk_i);
    chk("off_state", 32'h0000_0001, {ladder_power_o, ref_enable_o, display_active_o, contrast_open_o});
    rdc(OFS_PHASE, 32'h0000_0080);
    tally_and_finish;
  end
endmodule
